// ==== verilog/wdt_pkg.sv ====
// constants, types and state layout of the watchdog block
// assumes one 50 MHz clock, an 8-bit register port and a slow osc pin
// Contract
// - nonstop option always counts slow oscillator ticks
// - reset release starts slow clock, period 111
// - nonstop option cannot halt, counts through STOP
// - nonstop overflow after STOP gives internal reset
// - nonstop option ignores clock select bits
// - first write of mode register clears the counter
// - clear key write zeroes count and restarts
// - stoppable option lets software select clock
// - select 00 slow, 01 system, 1x stopped
// - period comes from mode bits 2 to 0
// - overflow after 2^(11+n) slow, 2^(13+n) system
// - second mode write, bad key, bit op reset
// - first write stopping watchdog suppresses those resets
// - stoppable option pauses in HALT and STOP
// - count is kept across HALT and STOP
// - idle stall of 34 us after STOP
// - crystal system clock waits stabilisation before stall
package wdt_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] MODE_ADDR = 16'hff48;
   localparam logic [15:0] CLEAR_ADDR = 16'hff49;
   localparam logic [7:0] MODE_RESET = 8'h67;
   localparam logic [7:0] CLEAR_READ = 8'h9a;
   localparam logic [7:0] CLEAR_KEY = 8'hac;
   localparam logic [2:0] MODE_FIXED = 3'h3;
   localparam logic [2:0] PERIOD_RESET = 3'h7;
   localparam logic [1:0] SELECT_RESET = 2'h0;
   localparam int CS_HI_POS = 4;
   localparam int CS_LO_POS = 3;
   localparam int PERIOD_MSB = 2;
   localparam int SLOW_BASE = 11;
   localparam int SYS_BASE = 13;
   localparam int CNT_W = 21;
   localparam int CLK_MHZ = 50;
   localparam int STALL_MIN_NS = 17000;
   localparam int STALL_TYP_NS = 34000;
   localparam int STALL_MAX_NS = 67000;
   localparam int STALL_W = 12;
   // typical stall, rounded up to whole clock cycles
   localparam logic [STALL_W-1:0] STALL_CYCLES =
      STALL_W'((STALL_TYP_NS * CLK_MHZ + 999) / 1000);

   typedef enum logic [1:0] {PH_RUN, PH_SUSPEND, PH_OSC_WAIT, PH_STALL}
      phase_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
      logic bit_op;
   } bus_req_type;

   typedef struct packed {
      logic opt_nonstop;
      logic opt_seen;
      logic [2:0] period;
      logic [1:0] select;
      logic written;
      logic stop_first;
      logic [CNT_W-1:0] count;
      phase_type phase;
      logic stop_seen;
      logic [STALL_W-1:0] stall_cnt;
      logic wdt_reset;
      logic [DATA_W-1:0] rd_data;
   } wdt_state_type;
endpackage

// ==== verilog/osc_tick_sync.sv ====
// three-stage synchroniser for the slow oscillator pin
// assumes the pin toggles well below clk/4; gives one pulse per rise
`timescale 1ns/1ps
module osc_tick_sync
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic async_in,
   output logic rise
);
   logic s1_q, s2_q, s3_q, lvl_q, rise_q;

   // a change counts only when the second and third stages agree
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
         rise_q <= 1'b0;
      end
      else
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            lvl_q <= s3_q;
         rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
      end
   end

   assign rise = rise_q;
endmodule // osc_tick_sync

// ==== verilog/wdt_core.sv ====
// watchdog counter with once-only mode register and keyed clear
// assumes halt/stop/osc_stable come from clk-domain logic
`timescale 1ns/1ps
module wdt_core
   import wdt_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic bit_op,
   input wire logic option_nonstop,
   input wire logic slow_osc_clock,
   input wire logic halt_mode,
   input wire logic stop_mode,
   input wire logic crystal_osc,
   input wire logic osc_stable,
   output logic [DATA_W-1:0] rd_data,
   output logic internal_reset,
   output logic wdt_running
);
   wdt_state_type s_q, s_d;
   bus_req_type req;
   logic slow_tick;
   logic sel_sys, stopped, paused, running, tick, overflow;
   logic mode_wr, clear_wr, key_ok, fault;
   logic [CNT_W-1:0] limit;
   logic running_q;
   logic [STALL_W-1:0] stall_len_q;

   // overflow limit: 2^(base+n)-1 ticks of the selected clock
   function automatic logic [CNT_W-1:0] ovf_limit(input logic [2:0] n,
                                                  input logic sys);
      logic [CNT_W-1:0] one;
      logic [4:0] sh;
      one = CNT_W'(1);
      sh = sys ? 5'(SYS_BASE) + 5'(n) : 5'(SLOW_BASE) + 5'(n);
      ovf_limit = (one << sh) - one;
   endfunction

   osc_tick_sync u_sync
   (
      .clk(clk),
      .resetn(resetn),
      .async_in(slow_osc_clock),
      .rise(slow_tick)
   );

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd,
                  bit_op: bit_op};

   // clock choice and run conditions
   always_comb
   begin
      sel_sys = !s_q.opt_nonstop && !s_q.select[1] && s_q.select[0];
      stopped = !s_q.opt_nonstop && s_q.select[1];
      // nonstop option never pauses, even in STOP
      paused = !s_q.opt_nonstop && (halt_mode || stop_mode);
      running = !stopped && !paused && (s_q.phase == PH_RUN) &&
                !s_q.wdt_reset;
      tick = sel_sys ? 1'b1 : slow_tick;
      limit = ovf_limit(s_q.period, sel_sys);
      overflow = running && tick && (s_q.count == limit);
      mode_wr = req.wr && (req.addr == MODE_ADDR);
      clear_wr = req.wr && (req.addr == CLEAR_ADDR);
      key_ok = (req.wdata == CLEAR_KEY) && !req.bit_op;
      fault = (mode_wr && s_q.written) || (clear_wr && !key_ok);
   end

   // next state of the whole block
   always_comb
   begin
      s_d = s_q;
      // strap is caught once, on the first edge after release
      if (!s_q.opt_seen)
      begin
         s_d.opt_seen = 1'b1;
         s_d.opt_nonstop = option_nonstop;
      end
      // count; a tick that hits the limit is the overflow
      if (running && tick)
         s_d.count = s_q.count + CNT_W'(1);
      // sticky until the system reset is applied
      if (overflow)
         s_d.wdt_reset = 1'b1;
      if (fault && !s_q.stop_first)
         s_d.wdt_reset = 1'b1;
      if (mode_wr && !s_q.written)
      begin
         s_d.written = 1'b1;
         s_d.period = req.wdata[PERIOD_MSB:0];
         // select bits are ignored with the nonstop option
         if (!s_q.opt_nonstop)
            s_d.select = req.wdata[CS_HI_POS:CS_LO_POS];
         s_d.stop_first = !s_q.opt_nonstop && req.wdata[CS_HI_POS];
         s_d.count = '0;
      end
      if (clear_wr && key_ok)
         s_d.count = '0;
      // suspend and resume around HALT and STOP, count held
      case (s_q.phase)
         PH_RUN:
         begin
            if (paused)
            begin
               s_d.phase = PH_SUSPEND;
               s_d.stop_seen = stop_mode;
            end
         end
         PH_SUSPEND:
         begin
            if (stop_mode)
               s_d.stop_seen = 1'b1;
            if (!halt_mode && !stop_mode)
            begin
               s_d.stall_cnt = STALL_CYCLES;
               if (!s_q.stop_seen)
                  s_d.phase = PH_RUN;
               else if (sel_sys && crystal_osc)
                  s_d.phase = PH_OSC_WAIT;
               else
                  s_d.phase = PH_STALL;
            end
         end
         PH_OSC_WAIT:
         begin
            if (osc_stable)
               s_d.phase = PH_STALL;
         end
         PH_STALL:
         begin
            if (s_q.stall_cnt == '0)
               s_d.phase = PH_RUN;
            else
               s_d.stall_cnt = s_q.stall_cnt - STALL_W'(1);
         end
         default:
            s_d.phase = PH_RUN;
      endcase
      // read data stands in the cycle after the strobe only
      s_d.rd_data = '0;
      if (req.rd && (req.addr == MODE_ADDR))
         s_d.rd_data = {MODE_FIXED, s_q.select, s_q.period};
      else if (req.rd && (req.addr == CLEAR_ADDR))
         s_d.rd_data = CLEAR_READ;
   end

   // single state register; reset gives slow clock and longest period
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_q <= '{opt_nonstop: 1'b1, opt_seen: 1'b0,
                  period: PERIOD_RESET, select: SELECT_RESET,
                  written: 1'b0, stop_first: 1'b0, count: '0,
                  phase: PH_RUN, stop_seen: 1'b0, stall_cnt: '0,
                  wdt_reset: 1'b0, rd_data: '0};
         running_q <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
         running_q <= running;
      end
   end

   assign rd_data = s_q.rd_data;
   assign internal_reset = s_q.wdt_reset;
   assign wdt_running = running_q;

   // checker helper: cycles spent so far in the resume stall; a counter
   // keeps the stall check cheap where a long delay would be unrolled
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         stall_len_q <= '0;
      else if (s_q.phase == PH_STALL)
         stall_len_q <= stall_len_q + STALL_W'(1);
      else
         stall_len_q <= '0;
   end

   // checks beside the logic
   a_reset_period: assert property (@(posedge clk) disable iff (!resetn)
      !s_q.written |-> s_q.period == 3'h7 && s_q.select == 2'h0)
      else $error("period or clock changed before first mode write");
   a_nonstop_slow: assert property (@(posedge clk) disable iff (!resetn)
      s_q.opt_nonstop |-> !sel_sys && !stopped && !paused)
      else $error("nonstop option left the slow clock or paused");
   a_nonstop_ignore: assert property (@(posedge clk) disable iff (!resetn)
      s_q.opt_nonstop && mode_wr |=> s_q.select == 2'h0)
      else $error("select bits taken in nonstop option");
   a_mode_clears: assert property (@(posedge clk) disable iff (!resetn)
      mode_wr && !s_q.written |=> s_q.count == '0 &&
      s_q.period == $past(wdata[2:0]))
      else $error("first mode write did not clear and load");
   a_key_clears: assert property (@(posedge clk) disable iff (!resetn)
      clear_wr && wdata == 8'hac && !bit_op |=> s_q.count == '0)
      else $error("key write did not clear the counter");
   a_bad_access: assert property (@(posedge clk) disable iff (!resetn)
      fault && !s_q.stop_first |=> internal_reset)
      else $error("illegal access gave no internal reset");
   a_stop_suppress: assert property (@(posedge clk) disable iff (!resetn)
      s_q.stop_first && !internal_reset |=> !internal_reset)
      else $error("reset raised while stopped by first write");
   a_pause_holds: assert property (@(posedge clk) disable iff (!resetn)
      s_q.phase != PH_RUN && !mode_wr && !clear_wr
      |=> s_q.count == $past(s_q.count))
      else $error("count changed while suspended");
   a_halt_pauses: assert property (@(posedge clk) disable iff (!resetn)
      !s_q.opt_nonstop && s_q.phase == PH_RUN && (halt_mode || stop_mode)
      |=> s_q.phase == PH_SUSPEND)
      else $error("halt or stop did not suspend counting");
   a_stall_start: assert property (@(posedge clk) disable iff (!resetn)
      $rose(s_q.phase == PH_STALL)
      |-> s_q.stall_cnt == STALL_CYCLES)
      else $error("resume stall loaded with wrong length");
   a_stall_holds: assert property (@(posedge clk) disable iff (!resetn)
      s_q.phase == PH_STALL && stall_len_q < STALL_CYCLES
      |=> s_q.phase == PH_STALL)
      else $error("resume stall ended too early");
   a_stall_ends: assert property (@(posedge clk) disable iff (!resetn)
      s_q.phase == PH_STALL && stall_len_q == STALL_CYCLES
      |=> s_q.phase == PH_RUN)
      else $error("resume stall length wrong");
   a_osc_wait: assert property (@(posedge clk) disable iff (!resetn)
      s_q.phase == PH_OSC_WAIT && !osc_stable
      |=> s_q.phase == PH_OSC_WAIT)
      else $error("stall began before oscillator stable");
   a_overflow_rst: assert property (@(posedge clk) disable iff (!resetn)
      running && tick && s_q.count == limit |=> internal_reset)
      else $error("overflow gave no internal reset");
   a_limit_shape: assert property (@(posedge clk) disable iff (!resetn)
      limit == ((21'd1 << (sel_sys ? 13 + s_q.period
                                   : 11 + s_q.period)) - 21'd1))
      else $error("overflow limit does not match period");
   // mode register reads its reset image until the first write
   a_reset_read: assert property (@(posedge clk) disable iff (!resetn)
      rd && addr == MODE_ADDR && !s_q.written
      |=> rd_data == MODE_RESET)
      else $error("mode register read differs from reset value");
   // nonstop option: nothing but an internal reset stops counting
   a_nonstop_runs: assert property (@(posedge clk) disable iff (!resetn)
      s_q.opt_nonstop && s_q.opt_seen && !s_q.wdt_reset
      |-> running)
      else $error("nonstop option stopped counting");

   c_overflow: cover property (@(posedge clk) disable iff (!resetn)
      overflow);
   c_stall: cover property (@(posedge clk) disable iff (!resetn)
      s_q.phase == PH_STALL && s_q.stall_cnt == '0);
   c_key: cover property (@(posedge clk) disable iff (!resetn)
      clear_wr && key_ok && s_q.written);
   c_stop_first: cover property (@(posedge clk) disable iff (!resetn)
      s_q.stop_first && fault);
endmodule // wdt_core

// ==== verification/tb_wdt_core.sv ====
// self-checking bench for the watchdog core: registers, faults, overflow
// assumes wdt_core checks itself with embedded assertions; 50 MHz clk
`timescale 1ns/1ps
module tb_wdt_core import wdt_pkg::*;;
   logic clk, resetn, wr, rd, bit_op, option_nonstop, slow_osc_clock;
   logic halt_mode, stop_mode, crystal_osc, osc_stable;
   logic internal_reset, wdt_running;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rd_data;
   logic [1:0] slow_div;
   int n_mismatch, n_compared;

   wdt_core i_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .bit_op(bit_op), .option_nonstop(option_nonstop),
      .slow_osc_clock(slow_osc_clock), .halt_mode(halt_mode),
      .stop_mode(stop_mode), .crystal_osc(crystal_osc),
      .osc_stable(osc_stable), .rd_data(rd_data),
      .internal_reset(internal_reset), .wdt_running(wdt_running));

   // 20 ns clock
   always #10 clk = ~clk;

   // slow oscillator at clk/8, well under the synchroniser limit
   always @(posedge clk)
   begin
      slow_div <= slow_div + 2'h1;
      if (slow_div == 2'h3)
         slow_osc_clock <= ~slow_osc_clock;
   end

   task compare(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task chk_flag(input logic got, input logic exp);
      compare({7'h00, got}, {7'h00, exp});
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task final_report();
      if (n_mismatch == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // full reset; the strap is caught on the first edge after release
   task do_reset(input logic ns);
      @(posedge clk);
      resetn <= 1'b0;
      option_nonstop <= ns;
      halt_mode <= 1'b0;
      stop_mode <= 1'b0;
      crystal_osc <= 1'b0;
      osc_stable <= 1'b1;
      cyc(12);
      resetn <= 1'b1;
      cyc(2);
   endtask

   task wr_reg(input logic [15:0] a, input logic [7:0] d, input logic b);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      bit_op <= b;
      @(posedge clk);
      wr <= 1'b0;
      bit_op <= 1'b0;
   endtask

   // read data is only valid in the cycle after the strobe
   task rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      compare(rd_data, exp);
   endtask

   // reset must be absent after lo cycles and present within slack more
   task overflow_at(input int lo, input int slack);
      int i;
      cyc(lo);
      @(negedge clk);
      chk_flag(internal_reset, 1'b0);
      i = 0;
      while (internal_reset !== 1'b1 && i < slack)
      begin
         @(negedge clk);
         i++;
      end
      chk_flag(internal_reset, 1'b1);
   endtask

   task t_reset_values();
      do_reset(1'b0);
      rd_chk(MODE_ADDR, MODE_RESET);
      rd_chk(CLEAR_ADDR, CLEAR_READ);
      rd_chk(16'hff4a, 8'h00);
      chk_flag(wdt_running, 1'b1);
   endtask

   task t_system_ack();
      do_reset(1'b0);
      wr_reg(MODE_ADDR, 8'h68, 1'b0);
      rd_chk(MODE_ADDR, 8'h68);
      cyc(6000);
      wr_reg(CLEAR_ADDR, CLEAR_KEY, 1'b0);
      overflow_at(8191, 1);
   endtask

   // pause in halt, then stop with crystal wait and resume stall
   task t_halt_stop();
      do_reset(1'b0);
      wr_reg(MODE_ADDR, 8'h69, 1'b0);
      cyc(2000);
      halt_mode <= 1'b1;
      cyc(1000);
      @(negedge clk);
      chk_flag(wdt_running, 1'b0);
      @(posedge clk);
      halt_mode <= 1'b0;
      cyc(2000);
      stop_mode <= 1'b1;
      crystal_osc <= 1'b1;
      osc_stable <= 1'b0;
      cyc(100);
      stop_mode <= 1'b0;
      cyc(500);
      @(negedge clk);
      chk_flag(wdt_running, 1'b0);
      @(posedge clk);
      osc_stable <= 1'b1;
      overflow_at(1701 + 12384 + 1, 1);
   endtask

   // stop with no crystal: straight into the resume stall, then a full period
   task t_stop_direct();
      do_reset(1'b0);
      wr_reg(MODE_ADDR, 8'h68, 1'b0);
      stop_mode <= 1'b1;
      cyc(10);
      stop_mode <= 1'b0;
      cyc(1000);
      @(negedge clk);
      chk_flag(wdt_running, 1'b0);
      overflow_at(8893, 1);
   endtask

   task t_faults();
      for (int k = 0; k < 3; k++)
      begin
         do_reset(1'b0);
         wr_reg(MODE_ADDR, 8'h68, 1'b0);
         case (k)
            0: wr_reg(MODE_ADDR, 8'h68, 1'b0);
            1: wr_reg(CLEAR_ADDR, 8'h00, 1'b0);
            default: wr_reg(CLEAR_ADDR, CLEAR_KEY, 1'b1);
         endcase
         cyc(1);
         @(negedge clk);
         chk_flag(internal_reset, 1'b1);
      end
   endtask

   // stopped on the first write: later misuse must not reset
   task t_stop_first();
      for (int s = 0; s < 2; s++)
      begin
         do_reset(1'b0);
         wr_reg(MODE_ADDR, s ? 8'h78 : 8'h70, 1'b0);
         rd_chk(MODE_ADDR, s ? 8'h78 : 8'h70);
         wr_reg(MODE_ADDR, 8'h68, 1'b0);
         wr_reg(CLEAR_ADDR, 8'h00, 1'b0);
         wr_reg(CLEAR_ADDR, CLEAR_KEY, 1'b1);
         cyc(20);
         @(negedge clk);
         chk_flag(internal_reset, 1'b0);
         chk_flag(wdt_running, 1'b0);
      end
   endtask

   // nonstop strap: select ignored, counts slow ticks through stop
   task t_nonstop();
      do_reset(1'b1);
      wr_reg(MODE_ADDR, 8'h78, 1'b0);
      rd_chk(MODE_ADDR, 8'h60);
      @(posedge clk);
      stop_mode <= 1'b1;
      halt_mode <= 1'b1;
      cyc(100);
      @(negedge clk);
      chk_flag(wdt_running, 1'b1);
      // clear from the slow timer interrupt while still in stop
      cyc(8000);
      chk_flag(internal_reset, 1'b0);
      wr_reg(CLEAR_ADDR, CLEAR_KEY, 1'b0);
      overflow_at(16360, 30);
   endtask

   // main sequence
   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      {wr, rd, bit_op, halt_mode, stop_mode, crystal_osc} = 6'h00;
      option_nonstop = 1'b0;
      osc_stable = 1'b1;
      slow_osc_clock = 1'b0;
      slow_div = 2'h0;
      addr = 16'h0000;
      wdata = 8'h00;
      n_mismatch = 0;
      n_compared = 0;
      t_reset_values();
      t_system_ack();
      t_halt_stop();
      t_stop_direct();
      t_faults();
      t_stop_first();
      t_nonstop();
      final_report();
   end

   // the run needs about 1.4 ms; give up at 2 ms (100k cycles)
   initial
   begin
      #2000000;
      n_mismatch++;
      final_report();
   end
endmodule // tb_wdt_core
